// >>> inc/rtcsel_consts.vh
// constants for the clock unit control and status block
// assumes an 8-bit register port addressed with 24-bit byte addresses
`ifndef RTCSEL_CONSTS_VH
`define RTCSEL_CONSTS_VH

// register addresses
`define RTCSEL_ADDR_W 24
`define RTCSEL_ADDR_FLAGS 24'hfff067
`define RTCSEL_ADDR_CTRL1 24'hfff06c
`define RTCSEL_ADDR_CTRL2 24'hfff06d
`define RTCSEL_ADDR_SRCSEL 24'hfff06f
`define RTCSEL_ADDR_IEN1 24'hfffff3

// field positions
`define RTCSEL_BIT_HALF_SEC 1
`define RTCSEL_BIT_SOFT_RST 4
`define RTCSEL_BIT_IRQ_REQ_EN 7
`define RTCSEL_BIT_SRC_RSVD 7
`define RTCSEL_OSEL_HI 6
`define RTCSEL_OSEL_LO 4
`define RTCSEL_SRC_HI 3
`define RTCSEL_SRC_LO 0

// reset values
`define RTCSEL_SRC_RESET 4'h8
`define RTCSEL_OSEL_RESET 3'h0
`define RTCSEL_BYTE_ZERO 8'h00

// output clock select codes, watch clock when bit 0 is set
`define RTCSEL_OSEL_DIV4 3'h0
`define RTCSEL_OSEL_DIV8 3'h2

// counting clock source codes
`define RTCSEL_SRC_WATCH 4'h8
`define RTCSEL_SRC_DIV512 4'h4
`define RTCSEL_SRC_DIV2048 4'h5
`define RTCSEL_SRC_DIV4096 4'h6
`define RTCSEL_SRC_DIV8192 4'h7

// prescaler, counter width and terminal masks
`define RTCSEL_PRE_W 13
`define RTCSEL_MASK_512 13'h01ff
`define RTCSEL_MASK_2048 13'h07ff
`define RTCSEL_MASK_4096 13'h0fff
`define RTCSEL_MASK_8192 13'h1fff
`define RTCSEL_PRE_DIV4_BIT 1
`define RTCSEL_PRE_DIV8_BIT 2

// half-second period in counting ticks, watch clock frequency in hz
`define RTCSEL_WATCH_HZ 32768
`define RTCSEL_HALF_W 14
`define RTCSEL_HALF_LAST 14'h3fff

`endif

// >>> src/rtcsel_prescale.v
// system clock prescaler giving counting ticks and output clock phases
// assumes clk is the system clock and sys_rst a synchronous reset
`timescale 1ns/1ps
`include "rtcsel_consts.vh"

module rtcsel_prescale (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // source code from the select register
   input wire [3:0] src_sel,
   // one-cycle tick of the chosen prescaled rate
   output reg pre_tick,
   // square waves of the system clock by 4 and by 8
   output wire div4_level,
   output wire div8_level
);

   reg [`RTCSEL_PRE_W-1:0] cnt_reg;

   // terminal mask for each prescaled source, zero mask means no tick
   function [`RTCSEL_PRE_W-1:0] src_mask;
      input [3:0] code;
      begin
         case (code)
            `RTCSEL_SRC_DIV512: src_mask = `RTCSEL_MASK_512;
            `RTCSEL_SRC_DIV2048: src_mask = `RTCSEL_MASK_2048;
            `RTCSEL_SRC_DIV4096: src_mask = `RTCSEL_MASK_4096;
            `RTCSEL_SRC_DIV8192: src_mask = `RTCSEL_MASK_8192;
            default: src_mask = {`RTCSEL_PRE_W{1'b0}};
         endcase
      end
   endfunction

   // free-running divider; all divisors share it so they stay in phase
   always @(posedge clk) begin
      if (sys_rst) begin
         cnt_reg <= {`RTCSEL_PRE_W{1'b0}};
         pre_tick <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
         pre_tick <= (src_mask(src_sel) != {`RTCSEL_PRE_W{1'b0}}) &&
            ((cnt_reg & src_mask(src_sel)) == src_mask(src_sel));
      end
   end

   assign div4_level = cnt_reg[`RTCSEL_PRE_DIV4_BIT];
   assign div8_level = cnt_reg[`RTCSEL_PRE_DIV8_BIT];

endmodule // rtcsel_prescale

// >>> src/rtcsel_top.v
// clock unit control: half-second interrupt, source and output select
// assumes a one-cycle strobe register port and synchronous inputs
//
// Summary of operation
// - half-second interrupt enable at control two bit 1
// - unit soft reset zeroes enable, half-second counter, flag
// - output pin: sys/4, sys/8 or watch clock
// - source codes pick watch or prescaled system clock
// - source select bit 7 reserved, writes ignored
// - half-second event sets flag bit 1
// - flag cleared by writing 0 while set
// - requests pass only while request enable bit 7 set
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "rtcsel_consts.vh"

module rtcsel_top (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // register port
   input wire [`RTCSEL_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // watch clock, sampled on clk
   input wire watch_clk,
   // pin function select for the clock output pin
   input wire clock_out_func_en,
   // external clock output pin
   output reg clock_output_pin,
   // interrupt request to the processor
   output reg irq
);

   // address decode, shared by the read and write paths
   function hit;
      input [`RTCSEL_ADDR_W-1:0] a;
      input [`RTCSEL_ADDR_W-1:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // register state
   reg half_second_irq_flag_reg;
   reg half_second_irq_flag_next;
   reg half_second_irq_enable_reg;
   reg half_second_irq_enable_next;
   reg soft_rst_reg;
   reg soft_rst_next;
   reg clock_irq_request_enable_reg;
   reg clock_irq_request_enable_next;
   reg [2:0] out_sel_reg;
   reg [2:0] out_sel_next;
   reg [3:0] src_sel_reg;
   reg [3:0] src_sel_next;

   // counting state
   reg watch_prev_reg;
   reg [`RTCSEL_HALF_W-1:0] half_cnt_reg;
   reg [`RTCSEL_HALF_W-1:0] half_cnt_next;
   reg div4_reg;
   reg div8_reg;
   reg watch_out_reg;

   // outputs
   reg [7:0] reg_rdata_next;
   reg clock_output_pin_next;
   reg irq_next;

   wire pre_tick;
   wire div4_level;
   wire div8_level;
   wire watch_tick;
   wire count_tick;
   wire half_event;
   wire wr_flags;
   wire wr_ctrl1;
   wire wr_ctrl2;
   wire wr_srcsel;
   wire wr_ien1;

   // prescaled system clock for free-running operation
   rtcsel_prescale u_prescale (
      .clk (clk),
      .sys_rst (sys_rst),
      .src_sel (src_sel_reg),
      .pre_tick (pre_tick),
      .div4_level (div4_level),
      .div8_level (div8_level)
   );

   // write decode
   assign wr_flags = reg_wr & hit(reg_addr, `RTCSEL_ADDR_FLAGS);
   assign wr_ctrl1 = reg_wr & hit(reg_addr, `RTCSEL_ADDR_CTRL1);
   assign wr_ctrl2 = reg_wr & hit(reg_addr, `RTCSEL_ADDR_CTRL2);
   assign wr_srcsel = reg_wr & hit(reg_addr, `RTCSEL_ADDR_SRCSEL);
   assign wr_ien1 = reg_wr & hit(reg_addr, `RTCSEL_ADDR_IEN1);

   // rising edge of the watch clock, used as the real-time tick
   assign watch_tick = watch_clk & ~watch_prev_reg;

   // counting tick: watch clock for code 1000, prescaler otherwise;
   // prohibited codes give no tick, so the counter just stops
   assign count_tick = (src_sel_reg == `RTCSEL_SRC_WATCH) ?
      watch_tick : pre_tick;

   // half period reached on the last tick of the count
   assign half_event = count_tick & (half_cnt_reg == `RTCSEL_HALF_LAST);

   // half-second counter; cleared while the unit is held in soft reset
   always @* begin
      half_cnt_next = half_cnt_reg;
      if (soft_rst_reg) begin
         half_cnt_next = {`RTCSEL_HALF_W{1'b0}};
      end else if (count_tick) begin
         half_cnt_next = half_cnt_reg + 1'b1;
      end
   end

   // soft reset bit itself; software must write it back to 0
   always @* begin
      soft_rst_next = soft_rst_reg;
      if (wr_ctrl1) begin
         soft_rst_next = reg_wdata[`RTCSEL_BIT_SOFT_RST];
      end
   end

   // half-second enable, loads 0 under the unit soft reset
   always @* begin
      half_second_irq_enable_next = half_second_irq_enable_reg;
      if (soft_rst_reg) begin
         half_second_irq_enable_next = 1'b0;
      end else if (wr_ctrl2) begin
         half_second_irq_enable_next =
            reg_wdata[`RTCSEL_BIT_HALF_SEC];
      end
   end

   // half-second flag: event set wins over a clear in the same cycle
   always @* begin
      half_second_irq_flag_next = half_second_irq_flag_reg;
      if (soft_rst_reg) begin
         half_second_irq_flag_next = 1'b0;
      end else if (half_event) begin
         half_second_irq_flag_next = 1'b1;
      end else if (wr_flags && half_second_irq_flag_reg &&
         !reg_wdata[`RTCSEL_BIT_HALF_SEC]) begin
         half_second_irq_flag_next = 1'b0;
      end
   end

   // source select; soft reset leaves it alone, bit 7 has no storage
   always @* begin
      src_sel_next = src_sel_reg;
      out_sel_next = out_sel_reg;
      if (wr_srcsel) begin
         src_sel_next = reg_wdata[`RTCSEL_SRC_HI:`RTCSEL_SRC_LO];
         out_sel_next = reg_wdata[`RTCSEL_OSEL_HI:`RTCSEL_OSEL_LO];
      end
   end

   // request enable sits in the interrupt controller, outside soft reset
   always @* begin
      clock_irq_request_enable_next = clock_irq_request_enable_reg;
      if (wr_ien1) begin
         clock_irq_request_enable_next =
            reg_wdata[`RTCSEL_BIT_IRQ_REQ_EN];
      end
   end

   // interrupt level follows the flag and both enables
   always @* begin
      irq_next = half_second_irq_flag_reg &
         half_second_irq_enable_reg &
         clock_irq_request_enable_reg;
   end

   // output clock choice; codes 100 and 110 have no clock, pin held low
   always @* begin
      clock_output_pin_next = 1'b0;
      if (clock_out_func_en) begin
         if (out_sel_reg[0]) begin
            clock_output_pin_next = watch_out_reg;
         end else begin
            case (out_sel_reg)
               `RTCSEL_OSEL_DIV4: clock_output_pin_next = div4_reg;
               `RTCSEL_OSEL_DIV8: clock_output_pin_next = div8_reg;
               default: clock_output_pin_next = 1'b0;
            endcase
         end
      end
   end

   // read mux; unmapped addresses and unused bits read as zero
   always @* begin
      reg_rdata_next = `RTCSEL_BYTE_ZERO;
      if (reg_rd) begin
         if (hit(reg_addr, `RTCSEL_ADDR_FLAGS)) begin
            reg_rdata_next[`RTCSEL_BIT_HALF_SEC] =
               half_second_irq_flag_reg;
         end else if (hit(reg_addr, `RTCSEL_ADDR_CTRL1)) begin
            reg_rdata_next[`RTCSEL_BIT_SOFT_RST] = soft_rst_reg;
         end else if (hit(reg_addr, `RTCSEL_ADDR_CTRL2)) begin
            reg_rdata_next[`RTCSEL_BIT_HALF_SEC] =
               half_second_irq_enable_reg;
         end else if (hit(reg_addr, `RTCSEL_ADDR_SRCSEL)) begin
            // reserved bit has no storage and always reads 0
            reg_rdata_next[`RTCSEL_BIT_SRC_RSVD] = 1'b0;
            reg_rdata_next[`RTCSEL_OSEL_HI:`RTCSEL_OSEL_LO] = out_sel_reg;
            reg_rdata_next[`RTCSEL_SRC_HI:`RTCSEL_SRC_LO] = src_sel_reg;
         end else if (hit(reg_addr, `RTCSEL_ADDR_IEN1)) begin
            reg_rdata_next[`RTCSEL_BIT_IRQ_REQ_EN] =
               clock_irq_request_enable_reg;
         end
      end
   end

   // control registers
   always @(posedge clk) begin
      if (sys_rst) begin
         half_second_irq_flag_reg <= 1'b0;
         half_second_irq_enable_reg <= 1'b0;
         soft_rst_reg <= 1'b0;
         clock_irq_request_enable_reg <= 1'b0;
         out_sel_reg <= `RTCSEL_OSEL_RESET;
         src_sel_reg <= `RTCSEL_SRC_RESET;
      end else begin
         half_second_irq_flag_reg <= half_second_irq_flag_next;
         half_second_irq_enable_reg <= half_second_irq_enable_next;
         soft_rst_reg <= soft_rst_next;
         clock_irq_request_enable_reg <= clock_irq_request_enable_next;
         out_sel_reg <= out_sel_next;
         src_sel_reg <= src_sel_next;
      end
   end

   // counter and clock-phase registers; the extra stage on each
   // phase keeps the pin glitch-free, at one cycle of delay
   always @(posedge clk) begin
      if (sys_rst) begin
         watch_prev_reg <= 1'b0;
         half_cnt_reg <= {`RTCSEL_HALF_W{1'b0}};
         div4_reg <= 1'b0;
         div8_reg <= 1'b0;
         watch_out_reg <= 1'b0;
      end else begin
         watch_prev_reg <= watch_clk;
         half_cnt_reg <= half_cnt_next;
         div4_reg <= div4_level;
         div8_reg <= div8_level;
         watch_out_reg <= watch_clk;
      end
   end

   // output registers
   always @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= `RTCSEL_BYTE_ZERO;
         clock_output_pin <= 1'b0;
         irq <= 1'b0;
      end else begin
         reg_rdata <= reg_rdata_next;
         clock_output_pin <= clock_output_pin_next;
         irq <= irq_next;
      end
   end

endmodule // rtcsel_top

// >>> verif/rtcsel_properties.sv
// assertions on the clock unit control block ports
// assumes the design constants header is on the include path
`timescale 1ns/1ps
`include "rtcsel_consts.vh"

module rtcsel_props (
   // clock and reset
   input wire clk,
   input wire sys_rst,
   // register port
   input wire [`RTCSEL_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // clocks, pin and interrupt
   input wire watch_clk,
   input wire clock_out_func_en,
   input wire clock_output_pin,
   input wire irq
);
   reg en_reg, ien_reg, srst_reg;
   reg [2:0] osel_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // shadows of written bits; soft reset wipes the enable like the unit
   always @(posedge clk) begin
      if (sys_rst) begin
         {en_reg, ien_reg, srst_reg, osel_reg} <= 6'h00;
      end else begin
         if (reg_wr && reg_addr == `RTCSEL_ADDR_CTRL1) begin
            srst_reg <= reg_wdata[4];
         end
         if (reg_wr && reg_addr == `RTCSEL_ADDR_IEN1) ien_reg <= reg_wdata[7];
         if (reg_wr && reg_addr == `RTCSEL_ADDR_SRCSEL) begin
            osel_reg <= reg_wdata[6:4];
         end
         if (srst_reg) begin
            en_reg <= 1'b0;
         end else if (reg_wr && reg_addr == `RTCSEL_ADDR_CTRL2) begin
            en_reg <= reg_wdata[1];
         end
      end
   end
   sequence src_rt_s;
      reg_wr && reg_addr == `RTCSEL_ADDR_SRCSEL ##2
      reg_rd && reg_addr == `RTCSEL_ADDR_SRCSEL;
   endsequence
   sequence en_rt_s;
      reg_wr && reg_addr == `RTCSEL_ADDR_CTRL2 && !srst_reg ##2
      reg_rd && reg_addr == `RTCSEL_ADDR_CTRL2;
   endsequence
   sequence flag_seen_s;
      reg_rd && reg_addr == `RTCSEL_ADDR_FLAGS && en_reg && ien_reg &&
      !srst_reg ##1 reg_rdata[1];
   endsequence
   src_readback_a: assert property (
      src_rt_s |=> reg_rdata == ($past(reg_wdata, 3) & 8'h7f))
      else $error("source select readback wrong");
   en_readback_a: assert property (
      en_rt_s |=> reg_rdata == ($past(reg_wdata, 3) & 8'h02))
      else $error("half second enable readback wrong");
   soft_reset_zero_a: assert property (
      reg_rd && srst_reg && $past(srst_reg) &&
      (reg_addr == `RTCSEL_ADDR_CTRL2 || reg_addr == `RTCSEL_ADDR_FLAGS)
      |=> reg_rdata == 8'h00) else $error("soft reset left bits set");
   irq_gate_a: assert property (
      irq |-> $past(en_reg) && $past(ien_reg))
      else $error("irq raised while disabled");
   irq_raise_a: assert property (
      flag_seen_s |-> irq) else $error("irq missing with flag set");
   irq_clear_a: assert property (
      reg_wr && reg_addr == `RTCSEL_ADDR_FLAGS && !reg_wdata[1] |-> ##2 !irq)
      else $error("irq stays after flag clear");
   pin_off_a: assert property (
      !clock_out_func_en [*4] |-> !clock_output_pin)
      else $error("clock pin driven while off");
   pin_div4_a: assert property (
      (clock_out_func_en && osel_reg == 3'h0) [*7] |->
      clock_output_pin != $past(clock_output_pin, 2))
      else $error("clock pin not quarter rate");
   pin_watch_a: assert property (
      (clock_out_func_en && osel_reg[0] && watch_clk) [*4] |->
      clock_output_pin)
      else $error("clock pin not following watch clock");
   // read data stands only in the cycle after a read strobe
   rdata_idle_a: assert property (
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read cycle");
   src_rsvd_zero_a: assert property (
      reg_rd && reg_addr == `RTCSEL_ADDR_SRCSEL |=> !reg_rdata[7])
      else $error("reserved source bit read as one");
endmodule // rtcsel_props

bind rtcsel_top rtcsel_props i_rtcsel_props (.clk(clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .watch_clk(watch_clk),
   .clock_out_func_en(clock_out_func_en),
   .clock_output_pin(clock_output_pin), .irq(irq));

// >>> verif/tb_top.sv
// self-checking bench for the clock unit control block
// assumes the design constants header is on the include path
`timescale 1ns/1ps
`include "rtcsel_consts.vh"

module tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic watch_clk = 1'b0, clock_out_func_en = 1'b0, wtog = 1'b0, wlev = 1'b0;
   logic [23:0] reg_addr = 24'h000000;
   logic [7:0] reg_wdata = 8'h00, d, r;
   logic [15:0] pv;
   wire [7:0] reg_rdata;
   wire clock_output_pin, irq;
   integer failures = 0, compares = 0, i;
   logic [23:0] ra [0:4] = '{`RTCSEL_ADDR_FLAGS, `RTCSEL_ADDR_CTRL2,
      `RTCSEL_ADDR_SRCSEL, `RTCSEL_ADDR_IEN1, 24'hfff068};
   logic [7:0] re [0:4] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
   // legal source codes only; prohibited codes are never written
   logic [3:0] src [0:4] = '{4'h8, 4'h4, 4'h5, 4'h6, 4'h7};
   rtcsel_top i_rtcsel_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .watch_clk(watch_clk),
      .clock_out_func_en(clock_out_func_en),
      .clock_output_pin(clock_output_pin), .irq(irq));
   // 40 mhz clock
   initial forever #12.5 clk = ~clk;
   // fast watch clock keeps a half-second event near 32768 cycles
   always @(posedge clk) watch_clk <= wtog ? ~watch_clk : wlev;
   task chk(input [15:0] got, input [15:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input [23:0] a, input [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [23:0] a, output [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task wrrd(input [23:0] a, input [7:0] v, input [7:0] m);
      wr(a, v);
      rd(a, r);
      chk(r, v & m);
   endtask
   // ones count in the high byte, edge count in the low byte
   task pin_meas(output [15:0] q);
      reg p;
      q = 16'h0000;
      cyc(1);
      p = clock_output_pin;
      repeat (16) begin
         cyc(1);
         q[15:8] = q[15:8] + clock_output_pin;
         q[7:0] = q[7:0] + (clock_output_pin != p);
         p = clock_output_pin;
      end
   endtask
   function [15:0] exp_pin(input [2:0] s);
      exp_pin = s[0] ? 16'h1000 : s == 3'h0 ? 16'h0808 :
         s == 3'h2 ? 16'h0804 : 16'h0000;
   endfunction
   task wait_irq;
      for (i = 0; i < 40000 && irq !== 1'b1; i = i + 1) cyc(1);
      chk(irq, 1'b1);
   endtask
   task report_and_stop;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // main sequence
   initial begin
      void'($urandom(88));
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
         rd(ra[i], d);
         chk(d, re[i]);
      end
      for (i = 0; i < 10; i = i + 1) begin
         d = $urandom;
         wrrd(`RTCSEL_ADDR_CTRL2, d, 8'h02);
         wrrd(`RTCSEL_ADDR_IEN1, d, 8'h80);
         d[3:0] = src[$urandom % 5];
         wrrd(`RTCSEL_ADDR_SRCSEL, d, 8'h7f);
      end
      @(posedge clk);
      clock_out_func_en <= 1'b1;
      wlev <= 1'b1;
      for (i = 0; i < 9; i = i + 1) begin
         // pin function off on the last pass, changed on a clock edge
         if (i == 8) begin
            @(posedge clk);
            clock_out_func_en <= 1'b0;
         end
         wr(`RTCSEL_ADDR_SRCSEL, {1'b0, i[2:0], 4'h8});
         cyc(6);
         pin_meas(pv);
         chk(pv, i == 8 ? 16'h0000 : exp_pin(i[2:0]));
      end
      wr(`RTCSEL_ADDR_SRCSEL, 8'h08);
      wr(`RTCSEL_ADDR_CTRL2, 8'h02);
      wr(`RTCSEL_ADDR_IEN1, 8'h80);
      wtog <= 1'b1;
      wait_irq;
      rd(`RTCSEL_ADDR_FLAGS, d);
      chk(d, 8'h02);
      wrrd(`RTCSEL_ADDR_FLAGS, 8'h02, 8'h02);
      for (i = 0; i < 3; i = i + 1) begin
         wr(i == 2 ? `RTCSEL_ADDR_CTRL2 : `RTCSEL_ADDR_IEN1, {i[0], 7'h00});
         cyc(3);
         chk(irq, i[0]);
      end
      wr(`RTCSEL_ADDR_CTRL2, 8'h02);
      wrrd(`RTCSEL_ADDR_FLAGS, 8'h00, 8'h00);
      cyc(2);
      chk(irq, 1'b0);
      wait_irq;
      wr(`RTCSEL_ADDR_CTRL1, 8'h10);
      cyc(2);
      for (i = 0; i < 3; i = i + 1) begin
         rd(ra[i], d);
         chk(d, re[i]);
      end
      chk(irq, 1'b0);
      wr(`RTCSEL_ADDR_CTRL1, 8'h00);
      report_and_stop;
   end
   // watchdog well beyond two half-second periods
   initial begin
      repeat (95000) @(posedge clk);
      failures = failures + 1;
      report_and_stop;
   end
endmodule // tb_top
